// ### src/rdi_ctrl_pkg.sv
// Shared constants and types for the path RDI insertion control block.
// Assumes an 8-bit register port with byte offsets as printed.
package rdi_ctrl_pkg;

	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CODE_W = 3;
	localparam int unsigned SPEED_W = 4;
	localparam int unsigned DEFECT_N = 5;

	// Register offsets
	localparam logic [ADDR_W-1:0] RDI_CTRL_2_ADDR = 16'h07C9;
	localparam logic [ADDR_W-1:0] RDI_CTRL_1_ADDR = 16'h07CA;
	localparam logic [ADDR_W-1:0] RDI_CTRL_0_ADDR = 16'h07CB;
	localparam logic [ADDR_W-1:0] RDI_STATUS_ADDR = 16'h07CC;
	localparam logic [ADDR_W-1:0] PORT_CLOCK_ADDR = 16'h07CF;

	// Reset values and register masks
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [SPEED_W-1:0] SPEED_RESET = 4'h0;
	localparam logic [DATA_W-1:0] CTRL_2_MASK = 8'h0F;
	localparam logic [DATA_W-1:0] PORT_CLOCK_MASK = 8'h0F;

	// Field positions in the control registers
	localparam int unsigned HI_CODE_LSB = 5;
	localparam int unsigned HI_EN_BIT = 4;
	localparam int unsigned LO_CODE_LSB = 1;
	localparam int unsigned LO_EN_BIT = 0;

	// RDI field position inside the G1 byte
	localparam int unsigned G1_RDI_LSB = 1;

	// Defect index within the sampled defect vector
	localparam int unsigned DEF_AIS = 4;
	localparam int unsigned DEF_LOP = 3;
	localparam int unsigned DEF_UNEQ = 2;
	localparam int unsigned DEF_TIM = 1;
	localparam int unsigned DEF_PLM = 0;

	typedef struct packed {
		logic [DATA_W-1:0]   ctrl2;
		logic [DATA_W-1:0]   ctrl1;
		logic [DATA_W-1:0]   ctrl0;
		logic [SPEED_W-1:0]  speed;
		logic [DATA_W-1:0]   rdata;
		logic [CODE_W-1:0]   code;
		logic                active;
		logic [DATA_W-1:0]   g1;
		logic [DEFECT_N-1:0] seen;
	} rdi_state_t;

	localparam rdi_state_t RDI_STATE_RESET = '{
		ctrl2:  CTRL_RESET,
		ctrl1:  CTRL_RESET,
		ctrl0:  CTRL_RESET,
		speed:  SPEED_RESET,
		rdata:  CTRL_RESET,
		code:   3'h0,
		active: 1'b0,
		g1:     8'h00,
		seen:   5'h00
	};

	typedef struct packed {
		logic [SPEED_W-1:0] count;
		logic               clk_out;
	} div_state_t;

	localparam div_state_t DIV_STATE_RESET = '{count: 4'h0, clk_out: 1'b0};

endpackage

// ### src/overhead_clock_divider.sv
// Overhead serial port clock divider.
// Assumes the divisor comes from a register in the same clock domain.
`timescale 1ns/1ns
module overhead_clock_divider
	import rdi_ctrl_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [SPEED_W-1:0] divisor,
	output wire logic               clk_out
);

	div_state_t s_q;
	div_state_t s_d;

	// Half period of divisor plus one source cycles
	always_comb begin
		s_d = s_q;
		if (s_q.count >= divisor) begin
			s_d.count = 4'h0;
			s_d.clk_out = ~s_q.clk_out;
		end else begin
			s_d.count = s_q.count + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= DIV_STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign clk_out = s_q.clk_out;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	toggle_when_due_a: assert property ((s_q.count >= divisor) |=> (clk_out != $past(clk_out)))
		else $error("Divided clock missed its toggle");
	hold_until_due_a: assert property ((s_q.count < divisor) |=> $stable(clk_out) && (s_q.count == $past(s_q.count) + 4'h1))
		else $error("Divided clock toggled early");

endmodule

// ### src/hp_rdi_auto_insert_ctrl.sv
// Path RDI automatic insertion control and overhead port clock setting.
// Assumes defect levels and frame start are synchronous to CORE_CLK.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module hp_rdi_auto_insert_ctrl
	import rdi_ctrl_pkg::*;
(
	input  wire logic              CORE_CLK,
	input  wire logic              RST_N,
	input  wire logic [ADDR_W-1:0] REG_ADDR,
	input  wire logic [DATA_W-1:0] REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output wire logic [DATA_W-1:0] REG_RDATA,
	input  wire logic              TRACE_MISMATCH_DEFECT,
	input  wire logic              UNEQUIPPED_PATH_DEFECT,
	input  wire logic              POINTER_LOSS_DEFECT,
	input  wire logic              ALARM_INDICATION_DEFECT,
	input  wire logic              PAYLOAD_LABEL_MISMATCH_DEFECT,
	input  wire logic              TX_FRAME_START,
	input  wire logic [DATA_W-1:0] G1_IN,
	output wire logic [DATA_W-1:0] G1_OUT,
	output wire logic [CODE_W-1:0] RDI_CODE,
	output wire logic              RDI_ACTIVE,
	output wire logic              OVERHEAD_PORT_TX_CLOCK
);

	rdi_state_t s_q;
	rdi_state_t s_d;

	logic [DEFECT_N-1:0] defects;
	logic [DEFECT_N-1:0] enables;
	logic [DEFECT_N-1:0] armed;
	logic [CODE_W-1:0]   codes [DEFECT_N];
	logic [CODE_W-1:0]   sel_code;
	logic                sel_any;

	assign defects[DEF_AIS] = ALARM_INDICATION_DEFECT;
	assign defects[DEF_LOP] = POINTER_LOSS_DEFECT;
	assign defects[DEF_UNEQ] = UNEQUIPPED_PATH_DEFECT;
	assign defects[DEF_TIM] = TRACE_MISMATCH_DEFECT;
	assign defects[DEF_PLM] = PAYLOAD_LABEL_MISMATCH_DEFECT;

	// Enable bits and stored codes per defect
	assign enables[DEF_AIS] = s_q.ctrl0[LO_EN_BIT];
	assign enables[DEF_LOP] = s_q.ctrl0[HI_EN_BIT];
	assign enables[DEF_UNEQ] = s_q.ctrl1[LO_EN_BIT];
	assign enables[DEF_TIM] = s_q.ctrl1[HI_EN_BIT];
	assign enables[DEF_PLM] = s_q.ctrl2[LO_EN_BIT];
	assign codes[DEF_AIS] = s_q.ctrl0[LO_CODE_LSB +: CODE_W];
	assign codes[DEF_LOP] = s_q.ctrl0[HI_CODE_LSB +: CODE_W];
	assign codes[DEF_UNEQ] = s_q.ctrl1[LO_CODE_LSB +: CODE_W];
	assign codes[DEF_TIM] = s_q.ctrl1[HI_CODE_LSB +: CODE_W];
	assign codes[DEF_PLM] = s_q.ctrl2[LO_CODE_LSB +: CODE_W];

	// A disabled defect never takes part in selection
	assign armed = defects & enables;

	// Fixed priority, highest index first
	always_comb begin
		sel_code = 3'h0;
		sel_any = 1'b0;
		for (int i = 0; i < DEFECT_N; i++) begin
			if (armed[i]) begin
				sel_code = codes[i];
				sel_any = 1'b1;
			end
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.rdata = 8'h00;
		if (REG_WR) begin
			unique case (REG_ADDR)
				RDI_CTRL_2_ADDR: s_d.ctrl2 = REG_WDATA & CTRL_2_MASK;
				RDI_CTRL_1_ADDR: s_d.ctrl1 = REG_WDATA;
				RDI_CTRL_0_ADDR: s_d.ctrl0 = REG_WDATA;
				PORT_CLOCK_ADDR: s_d.speed = REG_WDATA[SPEED_W-1:0];
				default: ;
			endcase
		end
		if (REG_RD) begin
			unique case (REG_ADDR)
				RDI_CTRL_2_ADDR: s_d.rdata = s_q.ctrl2;
				RDI_CTRL_1_ADDR: s_d.rdata = s_q.ctrl1;
				RDI_CTRL_0_ADDR: s_d.rdata = s_q.ctrl0;
				RDI_STATUS_ADDR: s_d.rdata = {s_q.code, s_q.seen};
				PORT_CLOCK_ADDR: s_d.rdata = {4'h0, s_q.speed} & PORT_CLOCK_MASK;
				default: s_d.rdata = 8'h00;
			endcase
		end
		// Selected code is held for a whole frame
		if (TX_FRAME_START) begin
			s_d.code = sel_any ? sel_code : 3'h0;
			s_d.active = sel_any;
			s_d.seen = armed;
		end
		// G1 passes through; RDI bits replaced only while active
		s_d.g1 = G1_IN;
		if (s_q.active) begin
			s_d.g1[G1_RDI_LSB +: CODE_W] = s_q.code;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			s_q <= RDI_STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign REG_RDATA = s_q.rdata;
	assign G1_OUT = s_q.g1;
	assign RDI_CODE = s_q.code;
	assign RDI_ACTIVE = s_q.active;

	// Software keeps the divisor inside the legal band
	overhead_clock_divider u_div (
		.clk     (CORE_CLK),
		.rst_n   (RST_N),
		.divisor (s_q.speed),
		.clk_out (OVERHEAD_PORT_TX_CLOCK)
	);

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	sequence frame_tick;
		TX_FRAME_START;
	endsequence

	sequence ais_wins;
		frame_tick ##0 (ALARM_INDICATION_DEFECT && s_q.ctrl0[LO_EN_BIT]);
	endsequence

	sequence lop_wins;
		frame_tick ##0 (POINTER_LOSS_DEFECT && s_q.ctrl0[HI_EN_BIT] && !armed[DEF_AIS]);
	endsequence

	sequence uneq_wins;
		frame_tick ##0 (UNEQUIPPED_PATH_DEFECT && s_q.ctrl1[LO_EN_BIT] && armed[4:3] == 2'b00);
	endsequence

	sequence tim_wins;
		frame_tick ##0 (TRACE_MISMATCH_DEFECT && s_q.ctrl1[HI_EN_BIT] && armed[4:2] == 3'b000);
	endsequence

	sequence plm_wins;
		frame_tick ##0 (PAYLOAD_LABEL_MISMATCH_DEFECT && s_q.ctrl2[LO_EN_BIT] && armed[4:1] == 4'h0);
	endsequence

	tim_code_sent_a: assert property (tim_wins |=> RDI_ACTIVE && RDI_CODE == $past(s_q.ctrl1[7:5]))
		else $error("Trace mismatch code not selected");
	tim_gate_off_a: assert property (frame_tick ##0 (defects == 5'h02 && !s_q.ctrl1[HI_EN_BIT]) |=> !RDI_ACTIVE)
		else $error("Trace mismatch inserted while disabled");
	uneq_code_sent_a: assert property (uneq_wins |=> RDI_ACTIVE && RDI_CODE == $past(s_q.ctrl1[3:1]))
		else $error("Unequipped code not selected");
	lop_code_sent_a: assert property (lop_wins |=> RDI_ACTIVE && RDI_CODE == $past(s_q.ctrl0[7:5]))
		else $error("Pointer loss code not selected");
	ais_code_sent_a: assert property (ais_wins |=> RDI_ACTIVE && RDI_CODE == $past(s_q.ctrl0[3:1]))
		else $error("Alarm indication code not selected");
	g1_untouched_a: assert property (!RDI_ACTIVE |=> G1_OUT == $past(G1_IN))
		else $error("G1 altered with no active defect");
	plm_code_sent_a: assert property (plm_wins |=> RDI_ACTIVE && RDI_CODE == $past(s_q.ctrl2[3:1]))
		else $error("Label mismatch code not selected");
	no_defect_idle_a: assert property (frame_tick ##0 (armed == 5'h00) |=> !RDI_ACTIVE && RDI_CODE == 3'h0)
		else $error("Code sent with no enabled defect");
	code_held_frame_a: assert property (!TX_FRAME_START |=> $stable(RDI_CODE) && $stable(RDI_ACTIVE))
		else $error("Code changed between frame starts");
	g1_carries_code_a: assert property (RDI_ACTIVE |=> G1_OUT[3:1] == $past(RDI_CODE)
		&& G1_OUT[7:4] == $past(G1_IN[7:4]) && G1_OUT[0] == $past(G1_IN[0]))
		else $error("G1 RDI bits not carrying the code");

	sequence ctrl1_read;
		REG_RD && REG_ADDR == RDI_CTRL_1_ADDR;
	endsequence

	sequence ctrl0_read;
		REG_RD && REG_ADDR == RDI_CTRL_0_ADDR;
	endsequence

	sequence ctrl2_read;
		REG_RD && REG_ADDR == RDI_CTRL_2_ADDR;
	endsequence

	sequence clock_read;
		REG_RD && REG_ADDR == PORT_CLOCK_ADDR;
	endsequence

	sequence status_read;
		REG_RD && REG_ADDR == RDI_STATUS_ADDR;
	endsequence

	rdata_idle_zero_a: assert property (!REG_RD |=> REG_RDATA == 8'h00)
		else $error("Read data stood past its cycle");
	ctrl1_readback_a: assert property (ctrl1_read |=> REG_RDATA == $past(s_q.ctrl1))
		else $error("Byte-1 control read back wrong");
	ctrl0_readback_a: assert property (ctrl0_read |=> REG_RDATA == $past(s_q.ctrl0))
		else $error("Byte-0 control read back wrong");
	ctrl2_upper_zero_a: assert property (ctrl2_read |=> REG_RDATA[7:4] == 4'h0)
		else $error("Byte-2 control unused bits not zero");
	clock_upper_zero_a: assert property (clock_read |=> REG_RDATA[7:4] == 4'h0)
		else $error("Port clock unused bits not zero");
	status_code_view_a: assert property (status_read |=> REG_RDATA[7:5] == $past(RDI_CODE))
		else $error("Status does not show the sent code");
	active_on_armed_a: assert property (frame_tick |=> RDI_ACTIVE == ($past(armed) != 5'h00))
		else $error("Active flag disagrees with enabled defects");
	ais_gate_off_a: assert property (frame_tick ##0 (defects == 5'h10 && !s_q.ctrl0[LO_EN_BIT]) |=> !RDI_ACTIVE)
		else $error("Alarm indication inserted while disabled");

endmodule

// ### test/rdi_far_end.sv
// Far-end model: frames the outbound G1 byte and reads back its RDI field.
// Assumes the bench and the block share one rising-edge clock.
`timescale 1ns/1ns
module rdi_far_end (
	input  wire logic       clk,
	input  wire logic       frame_req,
	input  wire logic [7:0] g1_out,
	output logic            frame_start,
	output logic [7:0]      g1_in,
	output logic [2:0]      rx_code
);
	initial begin
		frame_start = 1'b0;
		g1_in = 8'h00;
		rx_code = 3'h0;
	end
	always @(posedge clk) begin
		frame_start <= frame_req;
		g1_in <= g1_in + 8'h3B; // New byte every cycle
		rx_code <= g1_out[3:1];
	end
endmodule

// ### test/hp_rdi_auto_insert_ctrl_bench.sv
// Bench for the path RDI insertion control block.
// Assumes a far-end model file supplies frame starts and G1 bytes.
`timescale 1ns/1ns
module hp_rdi_auto_insert_ctrl_bench import rdi_ctrl_pkg::*;;
	logic        clk;
	logic        rst_n;
	logic        we;
	logic        re;
	logic        req;
	logic [15:0] adr;
	logic [7:0]  wd;
	logic [4:0]  def;
	wire  [7:0]  rdata;
	wire  [7:0]  g1i;
	wire  [7:0]  g1o;
	wire  [2:0]  code;
	wire  [2:0]  rxc;
	wire         act;
	wire         fs;
	wire         pclk;
	int          errors;
	int          comparisons;

	hp_rdi_auto_insert_ctrl dut (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(adr), .REG_WDATA(wd),
		.REG_WR(we), .REG_RD(re), .REG_RDATA(rdata), .TRACE_MISMATCH_DEFECT(def[1]),
		.UNEQUIPPED_PATH_DEFECT(def[2]), .POINTER_LOSS_DEFECT(def[3]), .ALARM_INDICATION_DEFECT(def[4]),
		.PAYLOAD_LABEL_MISMATCH_DEFECT(def[0]), .TX_FRAME_START(fs), .G1_IN(g1i), .G1_OUT(g1o),
		.RDI_CODE(code), .RDI_ACTIVE(act), .OVERHEAD_PORT_TX_CLOCK(pclk));
	rdi_far_end far (.clk(clk), .frame_req(req), .g1_out(g1o), .frame_start(fs), .g1_in(g1i), .rx_code(rxc));

	task summarize;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [7:0] a, input logic [7:0] e);
		comparisons++;
		if (a !== e) begin
			errors++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, a, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) begin adr <= a; wd <= d; we <= 1'b1; end
		@(posedge clk) we <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk) begin adr <= a; re <= 1'b1; end
		@(posedge clk) re <= 1'b0;
		@(negedge clk) chk(rdata, e);
	endtask
	task frm(input logic [4:0] d, input logic a, input logic [2:0] c);
		logic [7:0] g;
		@(posedge clk) begin def <= d; req <= 1'b1; end
		@(posedge clk) req <= 1'b0;
		@(posedge clk);
		@(negedge clk) chk(act, a);
		chk(code, a ? c : 3'h0);
		g = g1i;
		@(negedge clk) chk(g1o, a ? {g[7:4], c, g[0]} : g);
		@(negedge clk) chk(rxc, a ? c : g[3:1]);
	endtask
	task t_regs;
		rd(RDI_CTRL_1_ADDR, 8'h00);
		rd(RDI_CTRL_0_ADDR, 8'h00);
		rd(PORT_CLOCK_ADDR, 8'h00);
		wr(16'h0123, 8'hFF);
		rd(16'h0123, 8'h00);
		wr(RDI_CTRL_1_ADDR, 8'hFD);
		rd(RDI_CTRL_1_ADDR, 8'hFD);
		$display("register test done");
	endtask
	task t_each;
		wr(RDI_CTRL_0_ADDR, 8'h7B);
		wr(RDI_CTRL_2_ADDR, 8'hF5);
		rd(RDI_CTRL_2_ADDR, 8'h05);
		frm(5'b10000, 1'b1, 3'h5);
		frm(5'b01000, 1'b1, 3'h3);
		frm(5'b00100, 1'b1, 3'h6);
		frm(5'b00010, 1'b1, 3'h7);
		frm(5'b00001, 1'b1, 3'h2);
		frm(5'b11111, 1'b1, 3'h5);
		frm(5'b01111, 1'b1, 3'h3);
		frm(5'b00011, 1'b1, 3'h7);
		frm(5'b00000, 1'b0, 3'h0);
		$display("defect test done");
	endtask
	task t_off;
		wr(RDI_CTRL_1_ADDR, 8'hEC);
		wr(RDI_CTRL_0_ADDR, 8'h6A);
		wr(RDI_CTRL_2_ADDR, 8'h04);
		frm(5'b11111, 1'b0, 3'h0);
		frm(5'b00010, 1'b0, 3'h0);
		frm(5'b10000, 1'b0, 3'h0);
		wr(RDI_CTRL_1_ADDR, 8'hFC);
		frm(5'b11111, 1'b1, 3'h7);
		wr(RDI_STATUS_ADDR, 8'h00);
		rd(RDI_STATUS_ADDR, 8'hE2);
		@(posedge clk) def <= 5'h00;
		repeat (2) @(negedge clk);
		chk(code, 8'h07);
		chk(act, 8'h01);
		$display("enable test done");
	endtask
	task t_div;
		int n;
		wr(PORT_CLOCK_ADDR, 8'hF2);
		rd(PORT_CLOCK_ADDR, 8'h02);
		n = 0;
		while (pclk !== 1'b1 && n < 50) begin @(negedge clk); n++; end
		while (pclk === 1'b1 && n < 50) begin @(negedge clk); n++; end
		n = 0;
		while (pclk === 1'b0 && n < 50) begin @(negedge clk); n++; end
		chk(n[7:0], 8'h03);
		n = 0;
		while (pclk === 1'b1 && n < 50) begin @(negedge clk); n++; end
		chk(n[7:0], 8'h03);
		$display("divider test done");
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#400000;
		errors++;
		summarize;
	end
	initial begin
		rst_n = 1'b0;
		we = 1'b0;
		re = 1'b0;
		req = 1'b0;
		adr = 16'h0000;
		wd = 8'h00;
		def = 5'h00;
		errors = 0;
		comparisons = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_each;
		t_off;
		t_div;
		summarize;
	end
endmodule
